/* logic/bt_timer_ctl.v */
// base timer control: control register, run sync, reset sources, 16-bit counter
// assumes pins for count source, phases, up/down and interrupt pin are asynchronous,
// compare channel zero value comes from logic on the reference clock
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "bt_regs.vh"

// Summary of operation
// R1: With match reset selected, a counter equal to compare channel zero is cleared two count-source cycles later.
// R2: With match reset not selected, the counter runs straight through an equality with compare channel zero.
// R3: With pin reset selected the counter is held at zero while the interrupt pin is low, otherwise the pin is ignored.
// R4: The counter is held at zero while the run bit is 0 and counts while it is 1.
// R5: A run bit write takes effect only on a count-source edge, never directly from the register write.
// R6: Direction code 00 counts up, 01 counts up or down, 10 decodes two-phase pulses, and 11 must not be used.
// R7: Software changes the match reset select only while stopped and then sets the run bit.
// R8: Software changes the pin reset select only while stopped and then sets the run bit.
// R9: Software changes the direction field only while stopped and then sets the run bit.
// R10: Software disables the reload-match reset in the companion register whenever match reset is on.
// R11: Single-waveform or set-reset waveform output needs the direction field at up-counting.
// R12: Inverted waveform output needs the direction field at up or up/down counting.
// R13: Reserved control bits 0, 3 and 7 are written as zero, ignored by the device and read back as zero.
// R14: While running, the counter moves one step in the selected direction on each count-source rising edge, or on each phase A edge in two-phase mode.
module bt_timer_ctl #(
    parameter CNT_WIDTH = 16
) (
    input wire I_REF_CLK,
    input wire I_ARST_N,
    input wire [`BT_ADDR_WIDTH-1:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [7:0] O_RDATA,
    input wire I_BASE_TIMER_COUNT_SOURCE,
    input wire I_UP_DOWN,
    input wire I_PHASE_A,
    input wire I_PHASE_B,
    input wire I_EXTERNAL_INTERRUPT_PIN_ONE_N,
    input wire [CNT_WIDTH-1:0] I_OUTPUT_COMPARE_CHANNEL_ZERO,
    output reg [CNT_WIDTH-1:0] O_COUNT,
    output reg O_MATCH,
    output reg O_RUN
);

    // reset release
    reg rst_meta_n;
    reg rst_n;

    always @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // pin synchronisers
    wire [3:0] pins_sync;
    wire pin_int_n;

    bt_sync #(
        .WIDTH(4),
        .RST_VAL(4'h0)
    ) u_sync_count (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_async({I_PHASE_B, I_PHASE_A, I_UP_DOWN, I_BASE_TIMER_COUNT_SOURCE}),
        .o_sync(pins_sync)
    );

    // interrupt pin idles high, so its synchroniser resets high
    bt_sync #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) u_sync_int (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_async(I_EXTERNAL_INTERRUPT_PIN_ONE_N),
        .o_sync(pin_int_n)
    );

    // control register fields
    reg match_reset_select;
    reg pin_low_reset_select;
    reg timer_run_bit;
    reg [1:0] direction_field;

    wire ctl_hit;
    wire [7:0] ctl_value;

    assign ctl_hit = (I_ADDR == `BT_ADDR_CTL_ONE);

    // reserved positions are never stored and read as zero [R13]
    assign ctl_value = {1'b0,
                        direction_field,
                        timer_run_bit,
                        1'b0,
                        pin_low_reset_select,
                        match_reset_select,
                        1'b0};

    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            match_reset_select <= 1'b0;
            pin_low_reset_select <= 1'b0;
            timer_run_bit <= 1'b0;
            direction_field <= `BT_DIR_UP;
        end else if (I_WR && ctl_hit) begin
            // fields written while running are taken as is; software is expected to stop first
            match_reset_select <= I_WDATA[`BT_BIT_MATCH_RST];
            pin_low_reset_select <= I_WDATA[`BT_BIT_PIN_RST];
            timer_run_bit <= I_WDATA[`BT_BIT_RUN];
            direction_field <= I_WDATA[`BT_BIT_DIR_HI:`BT_BIT_DIR_LO];
        end
    end

    // step decoding
    wire src_tick;
    wire step;
    wire step_down;

    bt_step u_step (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_mode(direction_field), // [R6]
        .i_src(pins_sync[0]),
        .i_up_dn(pins_sync[1]),
        .i_ph_a(pins_sync[2]),
        .i_ph_b(pins_sync[3]),
        .o_tick(src_tick),
        .o_step(step),
        .o_down(step_down)
    );

    // run bit seen by the counter only moves on a count-source edge
    reg run_active;

    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            run_active <= 1'b0;
        end else if (src_tick) begin
            run_active <= timer_run_bit; // [R5]
        end
    end

    // compare match and its two-cycle delayed clear
    reg [CNT_WIDTH-1:0] count;
    reg match_pending;
    wire match_now;
    wire pin_reset;
    wire match_clear;

    assign match_now = run_active && (count == I_OUTPUT_COMPARE_CHANNEL_ZERO);
    // select off: equality is noticed but never clears the counter [R2]
    assign match_clear = src_tick && match_pending && match_reset_select; // [R1]
    assign pin_reset = pin_low_reset_select && !pin_int_n; // [R3]

    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            match_pending <= 1'b0;
        end else if (src_tick) begin
            // sampled at one source edge, acted on at the next: two cycles from the match [R1]
            match_pending <= match_now && match_reset_select && !match_clear;
        end else if (!run_active || pin_reset) begin
            match_pending <= 1'b0;
        end
    end

    // counter, reset sources first, then stepping
    reg [CNT_WIDTH-1:0] next_count;

    always @* begin
        next_count = count;
        if (!run_active) begin
            next_count = `BT_COUNT_RESET; // [R4]
        end else if (pin_reset) begin
            next_count = `BT_COUNT_RESET; // [R3]
        end else if (match_clear) begin
            next_count = `BT_COUNT_RESET; // [R1]
        end else if (step) begin
            // wraps freely at both ends [R14]
            if (step_down) begin
                next_count = count - {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            end else begin
                next_count = count + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            count <= `BT_COUNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    // outputs, all registered
    reg match_seen;

    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            match_seen <= 1'b0;
            O_MATCH <= 1'b0;
            O_RUN <= 1'b0;
            O_COUNT <= `BT_COUNT_RESET;
        end else begin
            match_seen <= match_now;
            // one pulse per equality, whatever the select
            O_MATCH <= match_now && !match_seen;
            O_RUN <= run_active;
            O_COUNT <= next_count;
        end
    end

    // register reads, data one cycle after the strobe
    wire [7:0] status_value;
    reg [7:0] next_rdata;

    assign status_value = {5'h00, !pin_int_n, match_pending, run_active};

    always @* begin
        next_rdata = 8'h00;
        if (ctl_hit) begin
            next_rdata = ctl_value;
        end else if (I_ADDR == `BT_ADDR_CNT_LO) begin
            next_rdata = count[7:0];
        end else if (I_ADDR == `BT_ADDR_CNT_HI) begin
            next_rdata = count[15:8];
        end else if (I_ADDR == `BT_ADDR_STATUS) begin
            next_rdata = status_value;
        end
    end

    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_RDATA <= 8'h00;
        end else if (I_RD) begin
            O_RDATA <= next_rdata;
        end else begin
            // data stand for one cycle only
            O_RDATA <= 8'h00;
        end
    end

endmodule

`default_nettype wire

/* common/bt_regs.vh */
// register offsets, field positions and codes for the base timer control block
// assumes a plain address/strobe register port with 12-bit byte addresses
`ifndef BT_REGS_VH
`define BT_REGS_VH

`define BT_ADDR_WIDTH 12
`define BT_ADDR_CTL_ONE 12'h2E3
`define BT_ADDR_CNT_LO 12'h2E0
`define BT_ADDR_CNT_HI 12'h2E1
`define BT_ADDR_STATUS 12'h2E2

`define BT_CTL_ONE_RESET 8'h00
`define BT_BIT_MATCH_RST 1
`define BT_BIT_PIN_RST 2
`define BT_BIT_RUN 4
`define BT_BIT_DIR_LO 5
`define BT_BIT_DIR_HI 6

`define BT_STAT_RUN 0
`define BT_STAT_MATCH_PEND 1
`define BT_STAT_PIN_LOW 2

`define BT_DIR_UP 2'h0
`define BT_DIR_UPDOWN 2'h1
`define BT_DIR_TWO_PHASE 2'h2
`define BT_DIR_FORBIDDEN 2'h3

`define BT_COUNT_RESET 16'h0000

`endif

/* logic/bt_sync.v */
// three-flop pin synchroniser, output moves once stages two and three agree
// assumes inputs arrive from outside the reference clock domain
`timescale 1ns/1ns
`default_nettype none

module bt_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // glitch filter: a one-cycle blip in stage two never reaches the output
    genvar k;
    generate
        for (k = 0; k < WIDTH; k = k + 1) begin : g_bit
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_sync[k] <= RST_VAL[k];
                end else if (stage2[k] == stage3[k]) begin
                    o_sync[k] <= stage3[k];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

/* logic/bt_step.v */
// step decoder: count-source edges, up/down select and two-phase pulses
// assumes all inputs are already synchronised to the reference clock
`timescale 1ns/1ns
`default_nettype none
`include "bt_regs.vh"

module bt_step (
    input wire i_clk,
    input wire i_rst_n,
    input wire [1:0] i_mode,
    input wire i_src,
    input wire i_up_dn,
    input wire i_ph_a,
    input wire i_ph_b,
    output reg o_tick,
    output reg o_step,
    output reg o_down
);

    reg src_d;
    reg ph_a_d;
    reg src_rise;
    reg a_edge;
    reg next_step;
    reg next_down;

    always @* begin
        src_rise = i_src & ~src_d;
        a_edge = i_ph_a ^ ph_a_d;
        next_step = 1'b0;
        next_down = 1'b0;
        case (i_mode)
            `BT_DIR_UP: begin
                next_step = src_rise;
            end
            `BT_DIR_UPDOWN: begin
                next_step = src_rise;
                next_down = i_up_dn;
            end
            `BT_DIR_TWO_PHASE: begin
                // phase b leading phase a means counting down
                next_step = a_edge;
                next_down = i_ph_a ? i_ph_b : ~i_ph_b;
            end
            default: begin
                // forbidden code: timer holds rather than guessing
                next_step = 1'b0;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_d <= 1'b0;
            ph_a_d <= 1'b0;
            o_tick <= 1'b0;
            o_step <= 1'b0;
            o_down <= 1'b0;
        end else begin
            src_d <= i_src;
            ph_a_d <= i_ph_a;
            o_tick <= src_rise;
            o_step <= next_step;
            o_down <= next_down;
        end
    end

endmodule

`default_nettype wire

/* sim/bt_timer_ctl_chk.sv */
// checker for the base timer control block, sees only top-level ports
// assumes the register port and the count source share the reference clock edge
`timescale 1ns/1ns
`default_nettype none
module bt_timer_ctl_chk #(
    parameter CNT_WIDTH = 16
) (
    input wire I_REF_CLK,
    input wire I_ARST_N,
    input wire [11:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    input wire [7:0] O_RDATA,
    input wire I_BASE_TIMER_COUNT_SOURCE,
    input wire I_EXTERNAL_INTERRUPT_PIN_ONE_N,
    input wire [CNT_WIDTH-1:0] O_COUNT,
    input wire O_MATCH,
    input wire O_RUN
);
    // shadow of the control register, rebuilt from bus writes
    logic [7:0] ctl;
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) ctl <= 8'h00;
        else if (I_WR && I_ADDR == 12'h2E3) ctl <= I_WDATA;
    end
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);
    property p_rd_idle; !$past(I_RD) |-> O_RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_ctl_rd; $past(I_RD && I_ADDR == 12'h2E3) |-> O_RDATA == (ctl & 8'h76); endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
    property p_stop; (!O_RUN)[*3] |-> O_COUNT == 0; endproperty
    a_stop: assert property (p_stop) else $error("count moves while stopped");
    // no source edge for a while means no sync tick can move the run state
    property p_sync; (!I_BASE_TIMER_COUNT_SOURCE)[*8] |-> $stable(O_RUN); endproperty
    a_sync: assert property (p_sync) else $error("run changed without source");
    property p_step;
        O_RUN && $past(O_RUN) && O_COUNT != $past(O_COUNT) && O_COUNT != 0
            |-> O_COUNT == $past(O_COUNT) + 1'b1 || O_COUNT == $past(O_COUNT) - 1'b1;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_once; O_MATCH |=> !O_MATCH; endproperty
    a_once: assert property (p_once) else $error("match pulse too long");
    property p_clr; O_MATCH && ctl[1] && O_RUN |-> ##[1:60] O_COUNT == 0; endproperty
    a_clr: assert property (p_clr) else $error("no clear after match");
    property p_noclr; O_MATCH && O_RUN && (ctl & 8'h66) == 8'h00 |-> (O_COUNT != 0)[*8]; endproperty
    a_noclr: assert property (p_noclr) else $error("cleared on match");
    property p_pin; (ctl[2] && !I_EXTERNAL_INTERRUPT_PIN_ONE_N)[*8] |-> O_COUNT == 0; endproperty
    a_pin: assert property (p_pin) else $error("pin low did not hold");
    property p_bad; (ctl[6:5] == 2'h3)[*4] |-> $stable(O_COUNT); endproperty
    a_bad: assert property (p_bad) else $error("counted in code 11");
    c_clr: cover property (O_MATCH && ctl[1]);
    c_pin: cover property (ctl[2] && !I_EXTERNAL_INTERRUPT_PIN_ONE_N && O_RUN);
    c_down: cover property (O_RUN && O_COUNT == 16'hFFFF);
endmodule
bind bt_timer_ctl bt_timer_ctl_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk (.I_REF_CLK, .I_ARST_N, .I_ADDR,
    .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_BASE_TIMER_COUNT_SOURCE, .I_EXTERNAL_INTERRUPT_PIN_ONE_N,
    .O_COUNT, .O_MATCH, .O_RUN);
`default_nettype wire

/* sim/tb_base_timer_control.sv */
// self-checking bench for the base timer control block
// assumes the checker file is compiled first and binds itself
`timescale 1ns/1ns
`default_nettype none
module tb_base_timer_control;
    logic I_REF_CLK = 1'b0;
    logic I_ARST_N = 1'b0;
    logic I_WR = 1'b0;
    logic I_RD = 1'b0;
    logic I_BASE_TIMER_COUNT_SOURCE = 1'b0;
    logic I_UP_DOWN = 1'b0;
    logic I_PHASE_A = 1'b0;
    logic I_PHASE_B = 1'b0;
    logic I_EXTERNAL_INTERRUPT_PIN_ONE_N = 1'b1;
    logic [11:0] I_ADDR = 12'h000;
    logic [7:0] I_WDATA = 8'h00;
    logic [15:0] I_OUTPUT_COMPARE_CHANNEL_ZERO = 16'h0100;
    wire [7:0] O_RDATA;
    wire [15:0] O_COUNT;
    wire O_MATCH;
    wire O_RUN;
    logic [3:0] ph = 4'h0;
    logic src_en = 1'b0;
    logic rev = 1'b0;
    logic [15:0] mx;
    int n_errors = 0;
    int checks = 0;
    bt_timer_ctl DUT (.I_REF_CLK, .I_ARST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
        .I_BASE_TIMER_COUNT_SOURCE, .I_UP_DOWN, .I_PHASE_A, .I_PHASE_B,
        .I_EXTERNAL_INTERRUPT_PIN_ONE_N, .I_OUTPUT_COMPARE_CHANNEL_ZERO, .O_COUNT, .O_MATCH, .O_RUN);
    initial begin
        forever #20 I_REF_CLK = ~I_REF_CLK;
    end
    // 16-cycle source period, phase b a quarter off; rev picks up or down
    always @(posedge I_REF_CLK) begin
        if (src_en) ph <= ph + 4'h1;
        I_BASE_TIMER_COUNT_SOURCE <= ph[3];
        I_PHASE_A <= ph[3];
        I_PHASE_B <= ph[3] ^ ph[2] ^ rev;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge I_REF_CLK);
    endtask
    task automatic ck(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge I_REF_CLK);
        I_WR <= 1'b1;
        I_ADDR <= 12'h2E3;
        I_WDATA <= d;
        @(posedge I_REF_CLK);
        I_WR <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge I_REF_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_REF_CLK);
        I_RD <= 1'b0;
        #1;
        ck(O_RDATA === e, "read data");
    endtask
    // highest count seen over n cycles
    task automatic run_max(input int n);
        mx = 16'h0000;
        repeat (n) begin
            @(posedge I_REF_CLK);
            #1;
            if (O_COUNT > mx) mx = O_COUNT;
        end
    endtask
    initial begin
        repeat (20000) @(posedge I_REF_CLK);
        n_errors++;
        end_sim;
    end
    initial begin
        cyc(5);
        I_ARST_N <= 1'b1;
        cyc(3);
        rd(12'h2E3, 8'h00);
        wr(8'h89);
        rd(12'h2E3, 8'h00);
        rd(12'h100, 8'h00);
        wr(8'h10);
        cyc(30);
        ck(O_RUN === 1'b0, "run before source");
        src_en <= 1'b1;
        cyc(100);
        ck(O_RUN === 1'b1, "run after sync");
        ck(O_COUNT > 16'h0000 && O_COUNT < 16'h0100, "up count");
        rd(12'h2E1, 8'h00);
        wr(8'h00);
        cyc(40);
        rd(12'h2E0, 8'h00);
        I_UP_DOWN <= 1'b1;
        wr(8'h20);
        wr(8'h30);
        cyc(100);
        ck(O_COUNT[15:8] === 8'hFF, "down count");
        wr(8'h00);
        cyc(40);
        rev <= 1'b1;
        wr(8'h40);
        wr(8'h50);
        cyc(100);
        ck(O_COUNT > 16'h0000 && O_COUNT < 16'h0100, "two-phase up");
        rev <= 1'b0;
        cyc(200);
        ck(O_COUNT[15:8] === 8'hFF, "two-phase down");
        wr(8'h00);
        cyc(40);
        wr(8'h60);
        wr(8'h70);
        cyc(100);
        ck(O_COUNT === 16'h0000, "code 11 held");
        wr(8'h00);
        cyc(40);
        I_UP_DOWN <= 1'b0;
        I_OUTPUT_COMPARE_CHANNEL_ZERO <= 16'h0005;
        wr(8'h02);
        wr(8'h12);
        run_max(300);
        ck(mx === 16'h0006, "match reset");
        wr(8'h00);
        cyc(40);
        wr(8'h10);
        run_max(400);
        ck(mx >= 16'h0010, "no match reset");
        wr(8'h00);
        cyc(40);
        wr(8'h04);
        wr(8'h14);
        cyc(60);
        I_EXTERNAL_INTERRUPT_PIN_ONE_N <= 1'b0;
        cyc(40);
        ck(O_COUNT === 16'h0000, "pin reset");
        rd(12'h2E2, 8'h05);
        I_EXTERNAL_INTERRUPT_PIN_ONE_N <= 1'b1;
        wr(8'h00);
        cyc(40);
        wr(8'h10);
        cyc(40);
        I_EXTERNAL_INTERRUPT_PIN_ONE_N <= 1'b0;
        cyc(60);
        ck(O_COUNT > 16'h0000 && O_COUNT < 16'h0100, "pin ignored");
        end_sim;
    end
endmodule
`default_nettype wire
